// [pkg/dmrs_pkg.sv]
// Purpose: Shared constants and types for the loop mode and reference
//          selection controller.
// Assumes: Registers sit on 32-bit Avalon-MM words at four times their index.
// Notes on behaviour
// [RULE_01] Mode field codes 00 freerun, 01 forced holdover, 10 forced lock, 11 automatic.
// [RULE_02] Automatic mode picks the active reference from availability and priority.
// [RULE_03] Automatic mode holds over only when none of the four references is usable.
// [RULE_04] Forced lock uses only the programmed reference and holds over if it fails.
// [RULE_05] Forced holdover ignores references and keeps the last selected one.
// [RULE_06] Freerun derives the loop outputs from the crystal input alone.
// [RULE_07] Feedback enable set uses the external feedback phase, clear ignores it.
// [RULE_08] The one external feedback phase is used whichever loop produced it.
// [RULE_09] In automatic mode the reference field reads back the selected reference.
// [RULE_10] In forced lock mode the reference field chooses reference 0 to 3.
// [RULE_11] In freerun and forced holdover the reference field is ignored.
// [RULE_12] A cleared holdover mask bit stops that failure kind forcing holdover.
// [RULE_13] Software never sets the soak timer hold bit without coarse or cycle bit.
// [RULE_14] A cleared switch mask bit stops that failure kind causing a switch.
// [RULE_15] Lower priority numbers win revertively and priority 111 disables.
// [RULE_16] Equal priorities switch non-revertively.
// [RULE_17] A reference is unusable while any unmasked monitor reports a failure.
package dmrs_pkg;
  localparam int NREF = 4;
  localparam int NMON = 4;
  localparam int ADDR_W = 10;
  localparam int PRIO_W = 3;
  localparam int PH_W = 16;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_MODE_REFSEL = 8'h33;
  localparam logic [7:0] IDX_FAIL_MASK = 8'h34;
  localparam logic [7:0] RST_MODE_REFSEL = 8'h03;
  localparam logic [7:0] RST_FAIL_MASK = 8'h87;
  // Field positions
  localparam int MODE_LSB = 0;
  localparam int FBEN_BIT = 5;
  localparam int REFSEL_LSB = 6;
  localparam int HOLD_MASK_LSB = 0;
  localparam int SW_MASK_LSB = 4;
  // Monitor order inside each failure nibble
  localparam int MON_ABSENT = 0;
  localparam int MON_SINGLE = 1;
  localparam int MON_COARSE = 2;
  localparam int MON_SOAK = 3;
  // Mode codes
  localparam logic [1:0] MODE_FREERUN = 2'h0;
  localparam logic [1:0] MODE_HOLD = 2'h1;
  localparam logic [1:0] MODE_FORCED = 2'h2;
  localparam logic [1:0] MODE_AUTO = 2'h3;
  localparam logic [PRIO_W-1:0] PRIO_DISABLED = 3'h7;

  typedef enum logic [1:0] {ST_FREERUN, ST_HOLDOVER, ST_LOCKED} dmrs_state_t;

  // Decision bundle driven to the loop
  typedef struct packed {
    dmrs_state_t state;
    logic [1:0] ref_idx;
    logic xtal_only;
    logic fb_en;
  } dmrs_loop_t;
endpackage

// [core/dmrs_ref_pick.sv]
// Purpose: Choose the usable reference with the lowest priority number.
// Assumes: Equal priorities resolve to the lowest index.
// Notes: Pure combinational; the caller decides whether to move.
`timescale 1ns/1ps
`default_nettype none
module dmrs_ref_pick
  import dmrs_pkg::*;
#(
  parameter int N = NREF
)
(
  input wire logic [N-1:0] usable,
  input wire logic [N-1:0][PRIO_W-1:0] prio,
  output logic found,
  output logic [1:0] idx,
  output logic [PRIO_W-1:0] best_prio
);
  if (N != NREF)
  begin : g_chk
    $error("dmrs_ref_pick serves exactly four references");
  end

  // Strict less-than keeps the first index among equal priorities
  always_comb
  begin
    found = 1'b0;
    idx = 2'h0;
    best_prio = PRIO_DISABLED;
    for (int i = 0; i < N; i++)
    begin
      if (usable[i] && prio[i] != PRIO_DISABLED // RULE_15
          && (!found || prio[i] < best_prio))
      begin
        found = 1'b1;
        idx = 2'(i);
        best_prio = prio[i];
      end
    end
  end
endmodule
`default_nettype wire

// [core/dmrs_mode_ctrl.sv]
// Purpose: Mode and reference selection control for one digital loop.
// Assumes: Failure flags and priorities come from logic on CLK_SYS.
// Notes: Registers answer Avalon-MM with one wait cycle per access.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module dmrs_mode_ctrl
  import dmrs_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [NREF-1:0][NMON-1:0] REF_FAIL,
  input wire logic [NREF-1:0][PRIO_W-1:0] REF_PRIORITY,
  input wire logic [PH_W-1:0] EXT_FB_PHASE,
  output dmrs_loop_t LOOP_CTRL,
  output logic [PH_W-1:0] FB_PHASE
);
  // Bus state
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  // Control registers
  logic [1:0] mode_r, mode_nxt;
  logic fb_en_r, fb_en_nxt;
  logic [1:0] refsel_r, refsel_nxt;
  logic [NMON-1:0] hold_mask_r, hold_mask_nxt;
  logic [NMON-1:0] sw_mask_r, sw_mask_nxt;
  // Loop decision state
  dmrs_state_t state_r, state_nxt;
  logic [1:0] ref_r, ref_nxt;
  logic [PH_W-1:0] fb_ph_r, fb_ph_nxt;
  // Decode helpers
  logic req, sel_mode, sel_mask, wr_now;
  logic [NREF-1:0] sw_bad, ho_bad;
  logic cand_ok, cur_bad;
  logic [1:0] cand_idx;
  logic [PRIO_W-1:0] cand_prio;
  logic [7:0] mode_rd;

  assign req = AVS_READ | AVS_WRITE;
  assign sel_mode = AVS_ADDRESS[ADDR_W-1:2] == IDX_MODE_REFSEL
                    && AVS_ADDRESS[1:0] == 2'h0;
  assign sel_mask = AVS_ADDRESS[ADDR_W-1:2] == IDX_FAIL_MASK
                    && AVS_ADDRESS[1:0] == 2'h0;
  // Held request is served on its second cycle, when waitrequest drops
  assign AVS_WAITREQUEST = req & ~ack_r;
  assign wr_now = AVS_WRITE & ack_r & AVS_BYTEENABLE[0];
  assign AVS_READDATA = rdata_r;

  // Availability per reference under each mask
  always_comb
  begin
    for (int i = 0; i < NREF; i++)
    begin
      sw_bad[i] = |(REF_FAIL[i] & sw_mask_r); // RULE_14 RULE_17
      ho_bad[i] = |(REF_FAIL[i] & hold_mask_r); // RULE_12
    end
  end

  // Best usable reference by priority
  dmrs_ref_pick #(.N(NREF)) u_pick (
    .usable(~sw_bad),
    .prio(REF_PRIORITY),
    .found(cand_ok),
    .idx(cand_idx),
    .best_prio(cand_prio)
  );

  // Current reference counts as lost if it failed or was disabled
  assign cur_bad = sw_bad[ref_r] || REF_PRIORITY[ref_r] == PRIO_DISABLED;

  // Readback of mode register; field shows status in automatic mode
  always_comb
  begin
    mode_rd = 8'h00;
    mode_rd[MODE_LSB +: 2] = mode_r;
    mode_rd[FBEN_BIT] = fb_en_r;
    mode_rd[REFSEL_LSB +: 2] = (mode_r == MODE_AUTO) ? ref_r // RULE_09
                                                     : refsel_r;
  end

  // Bus next values; unmapped reads give zero, unmapped writes drop
  always_comb
  begin
    ack_nxt = req & ~ack_r;
    rdata_nxt = rdata_r;
    mode_nxt = mode_r;
    fb_en_nxt = fb_en_r;
    refsel_nxt = refsel_r;
    hold_mask_nxt = hold_mask_r;
    sw_mask_nxt = sw_mask_r;
    if (AVS_READ && !ack_r)
    begin
      rdata_nxt = 32'h0000_0000;
      if (sel_mode)
        rdata_nxt[7:0] = mode_rd;
      else if (sel_mask)
        rdata_nxt[7:0] = {sw_mask_r, hold_mask_r};
    end
    if (wr_now && sel_mode)
    begin
      mode_nxt = AVS_WRITEDATA[MODE_LSB +: 2]; // RULE_01
      fb_en_nxt = AVS_WRITEDATA[FBEN_BIT]; // RULE_07
      // Status field is read-only while automatic mode is written
      if (AVS_WRITEDATA[MODE_LSB +: 2] != MODE_AUTO)
        refsel_nxt = AVS_WRITEDATA[REFSEL_LSB +: 2]; // RULE_10
    end
    if (wr_now && sel_mask)
    begin
      hold_mask_nxt = AVS_WRITEDATA[HOLD_MASK_LSB +: NMON]; // RULE_13
      sw_mask_nxt = AVS_WRITEDATA[SW_MASK_LSB +: NMON];
    end
  end

  // Register bus state and control fields
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      mode_r <= RST_MODE_REFSEL[MODE_LSB +: 2];
      fb_en_r <= RST_MODE_REFSEL[FBEN_BIT];
      refsel_r <= RST_MODE_REFSEL[REFSEL_LSB +: 2];
      hold_mask_r <= RST_FAIL_MASK[HOLD_MASK_LSB +: NMON];
      sw_mask_r <= RST_FAIL_MASK[SW_MASK_LSB +: NMON];
    end
    else
    begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      mode_r <= mode_nxt;
      fb_en_r <= fb_en_nxt;
      refsel_r <= refsel_nxt;
      hold_mask_r <= hold_mask_nxt;
      sw_mask_r <= sw_mask_nxt;
    end
  end

  // Loop state decision per mode
  always_comb
  begin
    state_nxt = state_r;
    ref_nxt = ref_r;
    case (mode_r)
      MODE_FREERUN: state_nxt = ST_FREERUN; // RULE_06 RULE_11
      MODE_HOLD: state_nxt = ST_HOLDOVER; // RULE_05 RULE_11
      MODE_FORCED:
      begin
        // No fallback: a failed forced reference only means holdover
        ref_nxt = refsel_r; // RULE_10
        state_nxt = ho_bad[refsel_r] ? ST_HOLDOVER : ST_LOCKED; // RULE_04
      end
      MODE_AUTO:
      begin
        // Move only on loss, when not locked, or on a strictly better priority
        if (cand_ok && (cur_bad || state_r != ST_LOCKED // RULE_02
            || cand_prio < REF_PRIORITY[ref_r])) // RULE_15 RULE_16
        begin
          ref_nxt = cand_idx;
          state_nxt = ST_LOCKED;
        end
        else if (!cand_ok && (ho_bad[ref_r] || state_r != ST_LOCKED))
          state_nxt = ST_HOLDOVER; // RULE_03
      end
      default: state_nxt = ST_FREERUN;
    endcase
    fb_ph_nxt = fb_en_r ? EXT_FB_PHASE : '0; // RULE_07 RULE_08
  end

  // Loop state registers
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_r <= ST_FREERUN;
      ref_r <= 2'h0;
      fb_ph_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      ref_r <= ref_nxt;
      fb_ph_r <= fb_ph_nxt;
    end
  end

  // Outputs to the loop
  assign LOOP_CTRL.state = state_r;
  assign LOOP_CTRL.ref_idx = ref_r;
  assign LOOP_CTRL.xtal_only = state_r == ST_FREERUN; // RULE_06
  assign LOOP_CTRL.fb_en = fb_en_r;
  assign FB_PHASE = fb_ph_r;

  // Checks on the decision logic and the bus
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  freerun_mode_a: assert property ( // RULE_06
    $past(mode_r) == MODE_FREERUN |-> state_r == ST_FREERUN
      && LOOP_CTRL.xtal_only)
    else $error("freerun mode did not give freerun state");

  hold_keeps_ref_a: assert property ( // RULE_05
    mode_r == MODE_HOLD && $past(mode_r) == MODE_HOLD
      |=> state_r == ST_HOLDOVER && $stable(ref_r))
    else $error("forced holdover changed reference or state");

  forced_lock_a: assert property ( // RULE_10
    mode_r == MODE_FORCED && !ho_bad[refsel_r]
      |=> state_r == ST_LOCKED && ref_r == $past(refsel_r))
    else $error("forced lock did not lock programmed reference");

  forced_fail_a: assert property ( // RULE_04
    mode_r == MODE_FORCED && ho_bad[refsel_r]
      |=> state_r == ST_HOLDOVER && ref_r == $past(refsel_r))
    else $error("forced reference failure did not hold over");

  auto_stays_locked_a: assert property ( // RULE_03
    mode_r == MODE_AUTO && cand_ok |=> state_r == ST_LOCKED)
    else $error("automatic mode left lock with a usable reference");

  auto_ref_usable_a: assert property ( // RULE_17
    mode_r == MODE_AUTO && cand_ok && cur_bad
      |=> ref_r == $past(cand_idx) && !$past(sw_bad[cand_idx]))
    else $error("automatic mode kept a lost reference");

  revert_a: assert property ( // RULE_15
    mode_r == MODE_AUTO && state_r == ST_LOCKED && cand_ok
      && cand_prio < REF_PRIORITY[ref_r] |=> ref_r == $past(cand_idx))
    else $error("no revert to better priority");

  no_equal_move_a: assert property ( // RULE_16
    mode_r == MODE_AUTO && state_r == ST_LOCKED && !cur_bad
      && cand_prio == REF_PRIORITY[ref_r] |=> $stable(ref_r))
    else $error("moved to an equal priority reference");

  fb_follow_a: assert property ( // RULE_07
    ##1 FB_PHASE == ($past(fb_en_r) ? $past(EXT_FB_PHASE) : '0))
    else $error("feedback phase does not follow enable");

  status_read_a: assert property ( // RULE_09
    AVS_READ && !ack_r && sel_mode && mode_r == MODE_AUTO
      |=> AVS_READDATA[REFSEL_LSB +: 2] == $past(ref_r)
      && !AVS_WAITREQUEST)
    else $error("status read wrong or late");

  auto_switch_c: cover property (
    mode_r == MODE_AUTO && cand_ok && cur_bad ##1 state_r == ST_LOCKED);
  auto_hold_c: cover property (
    mode_r == MODE_AUTO && state_r == ST_LOCKED ##1
    state_r == ST_HOLDOVER);
  forced_hold_c: cover property (
    mode_r == MODE_FORCED && state_r == ST_HOLDOVER);
  mask_write_c: cover property (wr_now && sel_mask);
endmodule
`default_nettype wire

// [test/dmrs_ref_model.sv]
// Purpose: Reference monitor and reference input model for the bench.
// Assumes: Bench commands change just after a rising edge.
// Notes: Flags follow the command one edge late, like registered monitors.
`timescale 1ns/1ps
`default_nettype none
module dmrs_ref_model
  import dmrs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [NREF-1:0][NMON-1:0] fail_cmd,
  input wire logic [NREF-1:0][PRIO_W-1:0] prio_cmd,
  output logic [NREF-1:0][NMON-1:0] ref_fail,
  output logic [NREF-1:0][PRIO_W-1:0] ref_prio,
  output logic [PH_W-1:0] fb_phase
);
  // Phase moves every cycle so a stale copy can never pass for a fresh one
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ref_fail <= '0;
      ref_prio <= '0;
      fb_phase <= '0;
    end
    else
    begin
      ref_fail <= fail_cmd;
      ref_prio <= prio_cmd;
      fb_phase <= fb_phase + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// [test/testbench.sv]
// Purpose: Self-checking bench for the loop mode controller.
// Assumes: One wait cycle per register access; loop follows an edge later.
// Notes: Each scenario task drives and judges before it returns.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import dmrs_pkg::*;
;
  localparam logic [9:0] MR = 10'h0cc;
  localparam logic [9:0] MK = 10'h0d0;
  localparam logic [11:0] P0 = 12'h688;
  localparam logic [11:0] PE = 12'h249;
  logic clk, arst_n, av_rd, av_wr, av_wait;
  logic [9:0] av_addr;
  logic [3:0] av_be;
  logic [31:0] av_wd, av_rdat, d;
  logic [NREF-1:0][NMON-1:0] fail_cmd, ref_fail;
  logic [NREF-1:0][PRIO_W-1:0] prio_cmd, ref_prio;
  logic [PH_W-1:0] fb_ext, fb_ph;
  dmrs_loop_t lc;
  int mismatches, num_checks;

  dmrs_mode_ctrl dmrs_mode_ctrl_i (.CLK_SYS(clk), .ARST_N(arst_n),
    .AVS_ADDRESS(av_addr), .AVS_READ(av_rd), .AVS_WRITE(av_wr),
    .AVS_WRITEDATA(av_wd), .AVS_BYTEENABLE(av_be), .AVS_READDATA(av_rdat),
    .AVS_WAITREQUEST(av_wait), .REF_FAIL(ref_fail),
    .REF_PRIORITY(ref_prio), .EXT_FB_PHASE(fb_ext), .LOOP_CTRL(lc),
    .FB_PHASE(fb_ph));
  dmrs_ref_model dmrs_ref_model_i (.clk(clk), .arst_n(arst_n),
    .fail_cmd(fail_cmd), .prio_cmd(prio_cmd), .ref_fail(ref_fail),
    .ref_prio(ref_prio), .fb_phase(fb_ext));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic lk(input dmrs_state_t s, input logic [1:0] i);
    chk({lc.state, lc.ref_idx}, {s, i});
  endtask

  // Waitrequest is sampled at the rising edge; all drives are non-blocking,
  // so the value seen is the one that stood before the edge
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk);
    av_addr <= a;
    av_wd <= {24'h000000, v};
    av_wr <= w;
    av_rd <= !w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (av_wait !== 1'b0 && n < 50);
    // A slave that never answers ends the run as a failure
    if (av_wait !== 1'b0)
    begin
      mismatches++;
      stop_test;
    end
    d = av_rdat;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask

  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Monitor flags and priorities reach the block one edge later
  task automatic drv(input logic [15:0] f, input logic [11:0] p);
    @(posedge clk);
    fail_cmd <= f;
    prio_cmd <= p;
    settle;
  endtask

  task automatic t_reset;
    bus(0, MR, 8'h00);
    chk(d, 32'h03);
    bus(0, MK, 8'h00);
    chk(d, 32'h87);
    bus(0, 10'h0d4, 8'h00);
    chk(d, 32'h00);
    lk(ST_LOCKED, 2'h0);
  endtask

  task automatic t_revert;
    drv(16'h0008, P0);
    lk(ST_LOCKED, 2'h1);
    bus(0, MR, 8'h00);
    chk(d, 32'h43);
    drv(16'h0008, 12'h6b8);
    lk(ST_LOCKED, 2'h2);
    drv(16'h0000, P0);
    lk(ST_LOCKED, 2'h0);
  endtask

  task automatic t_equal;
    drv(16'h0008, PE);
    lk(ST_LOCKED, 2'h1);
    drv(16'h0000, PE);
    lk(ST_LOCKED, 2'h1);
    // Absent and soak flags: lost under both default masks
    drv(16'h9999, PE);
    chk(lc.state, ST_HOLDOVER);
    drv(16'h9099, PE);
    lk(ST_LOCKED, 2'h2);
  endtask

  task automatic t_mask;
    drv(16'h0000, P0);
    bus(1, MK, 8'h07);
    drv(16'h0008, P0);
    lk(ST_LOCKED, 2'h0);
    bus(1, MK, 8'h87);
    settle;
    lk(ST_LOCKED, 2'h1);
    drv(16'h0000, P0);
  endtask

  // Every forced choice, then loss of the forced one
  task automatic t_forced;
    for (int r = 0; r < 4; r++)
    begin
      bus(1, MR, {r[1:0], 6'h02});
      settle;
      lk(ST_LOCKED, r[1:0]);
    end
    bus(0, MR, 8'h00);
    chk(d, 32'hc2);
    bus(1, MR, 8'h82);
    drv(16'h0100, P0);
    chk(lc.state, ST_HOLDOVER);
    bus(1, MK, 8'h86);
    settle;
    lk(ST_LOCKED, 2'h2);
    bus(1, MK, 8'h87);
    drv(16'h0000, P0);
  endtask

  task automatic t_modes;
    bus(1, MR, 8'hc1);
    drv(16'h1111, P0);
    lk(ST_HOLDOVER, 2'h2);
    bus(1, MR, 8'h40);
    drv(16'h0000, P0);
    chk({lc.state, lc.xtal_only}, {ST_FREERUN, 1'b1});
  endtask

  task automatic t_fb;
    bus(1, MR, 8'h23);
    settle;
    chk({lc.fb_en, fb_ph}, {1'b1, fb_ext - 16'h0001});
    bus(1, MR, 8'h03);
    settle;
    chk({lc.fb_en, fb_ph}, 17'h00000);
  endtask

  // Lane 0 off drops a write; a mid-run reset restores the defaults
  task automatic t_again;
    @(posedge clk);
    av_be <= 4'he;
    bus(1, MK, 8'h00);
    @(posedge clk);
    av_be <= 4'hf;
    bus(0, MK, 8'h00);
    chk(d, 32'h87);
    bus(1, MR, 8'h22);
    settle;
    lk(ST_LOCKED, 2'h0);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    bus(0, MR, 8'h00);
    chk(d, 32'h03);
    settle;
    chk({lc.fb_en, fb_ph}, 17'h00000);
    lk(ST_LOCKED, 2'h0);
  endtask

  task automatic stop_test;
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Free-running system clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Main sequence
  initial
  begin
    arst_n = 1'b0;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_addr = '0;
    av_wd = '0;
    av_be = 4'hf;
    fail_cmd = '0;
    prio_cmd = P0;
    mismatches = 0;
    num_checks = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    t_reset;
    t_revert;
    t_equal;
    t_mask;
    t_forced;
    t_modes;
    t_fb;
    t_again;
    stop_test;
  end

  // A hang counts against the run
  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    stop_test;
  end
endmodule
`default_nettype wire
